// ---- dv/dram_ctl_monitor.sv ----
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"
module dram_ctl_monitor #(
	parameter REFI_CYC  = `C_REFI,
	parameter SLEEP_CYC = `C_SLEEP
) (
	// clock and reset
	input wire               clk,
	input wire               sys_rst,
	// pins and state
	input wire               sleeping_q,
	input wire               ras_n_q,
	input wire               cas_n_q,
	input wire               we_n_q,
	input wire [`ADDR_W-1:0] addr_q,
	input wire [`DATA_W-1:0] dq_out_q,
	input wire               dq_oe_q
);
	reg [15:0] low_q;
	reg [15:0] gap_q;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// gap leaves room for one access still running when refresh falls due
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_q <= 16'h0;
			gap_q <= 16'h0;
		end else begin
			// saturates so a long sleep cannot wrap it back under the width limit
			low_q <= ras_n_q ? 16'h0 : (&low_q) ? low_q : low_q + 16'h1;
			gap_q <= (sleeping_q || (ras_n_q && !cas_n_q)) ? 16'h0 : gap_q + 16'h1;
		end
	end
	row_hold_a: assert property ($fell(ras_n_q) && cas_n_q |-> $stable(addr_q)[*3])
		else $error("row hold");
	ras_width_a: assert property ($rose(ras_n_q) |-> low_q >= `C_RAS)
		else $error("ras width");
	col_hold_a: assert property ($fell(cas_n_q) && !ras_n_q |->
		($stable(addr_q) && $stable(we_n_q))[*2]) else $error("col hold");
	wdata_hold_a: assert property ($fell(cas_n_q) && !we_n_q |->
		(dq_oe_q && $stable(dq_out_q))[*2]) else $error("data hold");
	precharge_a: assert property ($rose(ras_n_q) |-> ras_n_q[*8] ##1 ras_n_q[*2])
		else $error("precharge");
	cbr_order_a: assert property ($fell(ras_n_q) && !cas_n_q |->
		we_n_q && !$past(cas_n_q, 3)) else $error("refresh order");
	refresh_gap_a: assert property (gap_q <= REFI_CYC + 64)
		else $error("refresh late");
	sleep_entry_a: assert property ($rose(sleeping_q) |->
		!cas_n_q && low_q >= SLEEP_CYC - 1) else $error("sleep entry");
endmodule // dram_ctl_monitor
bind dram_ctl dram_ctl_monitor #(
	.REFI_CYC  (REFI_CYC),
	.SLEEP_CYC (SLEEP_CYC)
) mon (
	.clk        (clk),
	.sys_rst    (sys_rst),
	.sleeping_q (sleeping_q),
	.ras_n_q    (ras_n_q),
	.cas_n_q    (cas_n_q),
	.we_n_q     (we_n_q),
	.addr_q     (addr_q),
	.dq_out_q   (dq_out_q),
	.dq_oe_q    (dq_oe_q)
);

// ---- dv/dram_model.sv ----
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"
module dram_model (
	// strobes
	input wire                ras_n_q,
	input wire                cas_n_q,
	input wire                we_n_q,
	input wire                oe_n_q,
	// address and data
	input wire [`ADDR_W-1:0]  addr_q,
	input wire [`DATA_W-1:0]  dq_out_q,
	input wire                dq_oe_q,
	output wire [`DATA_W-1:0] dq_in
);
	reg [7:0] mem [int];
	reg [7:0] rd_q = 8'h00;
	reg [9:0] row_q = 10'h000;
	reg [9:0] ref_row_q = 10'h000;
	reg       rd_on_q = 1'b0;
	reg       acc_q = 1'b0;
	// one counter serves column-first and hidden refresh; it advances only on a row strobe fall, never during sleep
	always @(negedge ras_n_q)
		if (cas_n_q)
			row_q = addr_q;
		else
			ref_row_q = ref_row_q + 10'h001;
	always @(negedge cas_n_q)
		if (!ras_n_q) begin
			rd_on_q = we_n_q;
			if (!we_n_q)
				mem[{row_q, addr_q}] = dq_out_q;
			else
				rd_q = mem[{row_q, addr_q}];
		end
	always @(posedge cas_n_q) rd_on_q = 1'b0;
	// data settles just short of the access time, so an early sample sees the wrong word
	always @(negedge cas_n_q) begin
		acc_q = 1'b0;
		#(`T_ACC_NS - 1) acc_q = !cas_n_q;
	end
	// a released bus shows the inverse of the last word, not a kind leftover
	assign dq_in = dq_oe_q ? dq_out_q :
		(rd_on_q && acc_q && !oe_n_q) ? rd_q : ~rd_q;
endmodule // dram_model

// ---- dv/dram_strobe_sequencing_test.sv ----
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"
module dram_strobe_sequencing_test;
	reg        clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, sleep_req = 1'b0;
	reg [1:0]  req_op = 2'h0;
	reg [9:0]  req_row = 10'h000, req_col = 10'h000;
	reg [7:0]  req_wdata = 8'h00, wd [0:15];
	reg [19:0] ad [0:15];
	wire       req_ready, rd_valid_q, sleeping_q, ras_n_q, cas_n_q, we_n_q, oe_n_q, dq_oe_q;
	wire [9:0] addr_q;
	wire [7:0] rd_data_q, dq_out_q, dq_in;
	integer    seed = 32'h8BDA39A8, num_errors = 0, comparisons = 0, i, n;
	reg [7:0]  expq [$];
	dram_ctl #(
		.REFI_CYC  (200),
		.SLEEP_CYC (50)
	) DUT (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.req_valid  (req_valid),
		.req_ready  (req_ready),
		.req_op     (req_op),
		.req_row    (req_row),
		.req_col    (req_col),
		.req_wdata  (req_wdata),
		.rd_data_q  (rd_data_q),
		.rd_valid_q (rd_valid_q),
		.sleep_req  (sleep_req),
		.sleeping_q (sleeping_q),
		.ras_n_q    (ras_n_q),
		.cas_n_q    (cas_n_q),
		.we_n_q     (we_n_q),
		.oe_n_q     (oe_n_q),
		.addr_q     (addr_q),
		.dq_out_q   (dq_out_q),
		.dq_oe_q    (dq_oe_q),
		.dq_in      (dq_in)
	);
	dram_model dev (
		.ras_n_q  (ras_n_q),
		.cas_n_q  (cas_n_q),
		.we_n_q   (we_n_q),
		.oe_n_q   (oe_n_q),
		.addr_q   (addr_q),
		.dq_out_q (dq_out_q),
		.dq_oe_q  (dq_oe_q),
		.dq_in    (dq_in)
	);
	initial forever #2 clk = ~clk;
	task check(input [7:0] got, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	// request stays up after acceptance so back-to-back calls never pulse it
	task req(input [1:0] op, input [19:0] a, input [7:0] d);
		begin
			{req_op, req_row, req_col, req_wdata, req_valid} = {op, a, d, 1'b1};
			if (op == 2'h0 || op == 2'h3)
				expq.push_back(d);
			for (n = 0; n < 300 && !req_ready; n = n + 1) @(posedge clk) #1;
			// a request never taken within the limit counts as a mismatch
			check({7'h00, req_ready}, 8'h01);
			@(posedge clk) #1;
		end
	endtask
	task final_report;
		begin
			$display("errors %0d comparisons %0d", num_errors, comparisons);
			if (num_errors == 0 && comparisons > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (i = 0; i < 16; i = i + 1) begin
			ad[i] = {4'(i), i == 15 ? 16'hFFFF : 16'($random(seed))};
			wd[i] = 8'($random(seed));
			req(2'h1, ad[i], ~wd[i]);
			req(2'h1, ad[i], wd[i]);
		end
		req_valid = 1'b0;
		repeat (300) @(posedge clk) #1;
		for (i = 15; i >= 0; i = i - 1) begin
			req(i[0] ? 2'h3 : 2'h0, ad[i], wd[i]);
			req(2'h2, 20'($random(seed)), 8'h00);
		end
		req_valid = 1'b0;
		sleep_req = 1'b1;
		for (n = 0; n < 150 && sleeping_q !== 1'b1; n = n + 1) @(posedge clk) #1;
		repeat (100) @(posedge clk) #1;
		check({6'h00, sleeping_q, req_ready}, 8'h02);
		sleep_req = 1'b0;
		for (n = 0; n < 20 && sleeping_q !== 1'b0; n = n + 1) @(posedge clk) #1;
		repeat (3) @(posedge clk) #1;
		check({6'h00, ras_n_q, cas_n_q}, 8'h03);
		for (i = 0; i < 16; i = i + 1)
			req(2'h0, ad[i], wd[i]);
		req_valid = 1'b0;
		for (n = 0; n < 100 && expq.size() > 0; n = n + 1) @(posedge clk) #1;
		check(8'(expq.size()), 8'h00);
		final_report;
	end
	always @(negedge clk)
		if (rd_valid_q === 1'b1) begin
			// a read result with nothing noted for it is itself a mismatch
			check({7'h00, expq.size() != 0}, 8'h01);
			if (expq.size() != 0)
				check(rd_data_q, expq.pop_front());
		end
	initial begin
		#100000 num_errors = num_errors + 1;
		final_report;
	end
endmodule // dram_strobe_sequencing_test

// ---- hw/dram_ctl.v ----
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"

// Function
// RL1: device drives data only when gate low
// RL2: device ignores gate during writes
// RL3: device floats data outside read phase
// RL4: high stores one, low stores zero
// RL5: row address set up, held after fall
// RL6: row strobe falls, low for minimum
// RL7: column address set up, held; strobe minimum
// RL8: write select high around column fall
// RL9: read data valid after latest access
// RL10: both strobes high, precharge before next
// RL11: write column after row fall, held
// RL12: write select low pulse around column
// RL13: write data set up and held
// RL14: any access restores its row
// RL15: spread refresh over every interval
// RL16: supplied row refresh, column strobe high
// RL17: column first refresh strobe order
// RL18: device uses internal row counter
// RL19: device supports hidden refresh
// RL20: hold row strobe 100 us for sleep
// RL21: device self-times sleep refresh
// RL22: both strobes high end sleep refresh
// RL23: write select sampled at column fall
// RL24: column first refresh needs no counter
// RL25: device advances internal row counter
module dram_ctl #(
	parameter REFI_CYC  = `C_REFI,
	parameter SLEEP_CYC = `C_SLEEP
) (
	// clock and reset
	input  wire                 clk,
	input  wire                 sys_rst,
	// user request
	input  wire                 req_valid,
	output wire                 req_ready,
	input  wire [1:0]           req_op,
	input  wire [`ADDR_W-1:0]   req_row,
	input  wire [`ADDR_W-1:0]   req_col,
	input  wire [`DATA_W-1:0]   req_wdata,
	output reg  [`DATA_W-1:0]   rd_data_q,
	output reg                  rd_valid_q,
	// sleep control
	input  wire                 sleep_req,
	output reg                  sleeping_q,
	// dram pins
	output reg                  ras_n_q,
	output reg                  cas_n_q,
	output reg                  we_n_q,
	output reg                  oe_n_q,
	output reg  [`ADDR_W-1:0]   addr_q,
	output reg  [`DATA_W-1:0]   dq_out_q,
	output reg                  dq_oe_q,
	input  wire [`DATA_W-1:0]   dq_in
);
	localparam S_IDLE  = 4'h0;
	localparam S_ASR   = 4'h1;
	localparam S_RAH   = 4'h2;
	localparam S_COL   = 4'h3;
	localparam S_CAS   = 4'h4;
	localparam S_PRE   = 4'h5;
	localparam S_RREF  = 4'h6;
	localparam S_CSR   = 4'h7;
	localparam S_CBR   = 4'h8;
	localparam S_CHR   = 4'h9;
	localparam S_SLEEP = 4'hA;

	reg  [3:0]          state_q;
	reg  [23:0]         cnt_q;
	reg  [23:0]         ras_cnt_q;
	reg  [1:0]          op_q;
	reg  [`DATA_W-1:0]  wdata_q;
	reg  [`ADDR_W-1:0]  col_q;
	reg                 ref_ack;
	wire                ref_due;

	refresh_timer #(
		.PERIOD (REFI_CYC)
	) u_refresh_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ack     (ref_ack),
		.due_q   (ref_due)
	);

	// refresh and sleep take priority, so an access only starts when neither is pending
	assign req_ready = (state_q == S_IDLE) && !ref_due && !sleep_req;

	always @* begin
		ref_ack = (state_q == S_IDLE) && ref_due && !sleep_req; // [RL15]
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= S_IDLE;
			cnt_q      <= 24'h000000;
			ras_cnt_q  <= 24'h000000;
			op_q       <= 2'h0;
			wdata_q    <= {`DATA_W{1'b0}};
			col_q      <= {`ADDR_W{1'b0}};
			rd_data_q  <= {`DATA_W{1'b0}};
			rd_valid_q <= 1'b0;
			sleeping_q <= 1'b0;
			ras_n_q    <= 1'b1;
			cas_n_q    <= 1'b1;
			we_n_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			addr_q     <= {`ADDR_W{1'b0}};
			dq_out_q   <= {`DATA_W{1'b0}};
			dq_oe_q    <= 1'b0;
		end else begin
			rd_valid_q <= 1'b0;
			cnt_q      <= cnt_q + 24'h000001;
			ras_cnt_q  <= ras_n_q ? 24'h000000 : ras_cnt_q + 24'h000001;
			case (state_q)
			S_IDLE: begin
				cnt_q <= 24'h000000;
				if (sleep_req || ref_due) begin
					// column first refresh: no row counter needed here
					cas_n_q <= 1'b0; // [RL17] [RL24]
					we_n_q  <= 1'b1; // [RL17]
					state_q <= S_CSR;
				end else if (req_valid) begin
					op_q    <= req_op;
					col_q   <= req_col;
					wdata_q <= req_wdata;
					addr_q  <= req_row; // [RL5] [RL16]
					state_q <= S_ASR;
				end
			end
			S_ASR: begin
				if (cnt_q == `C_ASR - 1) begin
					ras_n_q <= 1'b0; // [RL6]
					cnt_q   <= 24'h000000;
					state_q <= (op_q == `OP_ROW_REF) ? S_RREF : S_RAH;
				end
			end
			S_RAH: begin
				// row held until the hold time passes, then the column appears
				if (cnt_q == `C_RAH - 1) begin
					addr_q  <= col_q; // [RL5] [RL11]
					we_n_q  <= (op_q != `OP_WRITE); // [RL8] [RL12]
					dq_out_q <= wdata_q; // [RL13]
					dq_oe_q <= (op_q == `OP_WRITE); // [RL13]
					cnt_q   <= 24'h000000;
					state_q <= S_COL;
				end
			end
			S_COL: begin
				if (cnt_q == `C_RCD - `C_RAH - 1) begin
					cas_n_q <= 1'b0; // [RL7]
					oe_n_q  <= (op_q == `OP_WRITE); // [RL2]
					cnt_q   <= 24'h000000;
					state_q <= S_CAS;
				end
			end
			S_CAS: begin
				// wait out both the column minimum and the slowest access path
				if (cnt_q >= `C_CAS - 1 && cnt_q >= `C_ACC - 1 &&
				    ras_cnt_q >= `C_RAS - 1) begin
					if (op_q != `OP_WRITE) begin
						rd_data_q  <= dq_in; // [RL9]
						rd_valid_q <= 1'b1;
					end
					ras_n_q <= 1'b1; // [RL10]
					cas_n_q <= 1'b1; // [RL10] [RL7]
					oe_n_q  <= 1'b1;
					we_n_q  <= 1'b1; // [RL8] [RL12]
					dq_oe_q <= 1'b0; // [RL13]
					cnt_q   <= 24'h000000;
					state_q <= S_PRE;
				end
			end
			S_RREF: begin
				if (cnt_q == `C_RAS - 1) begin
					ras_n_q <= 1'b1; // [RL16]
					cnt_q   <= 24'h000000;
					state_q <= S_PRE;
				end
			end
			S_CSR: begin
				if (cnt_q == `C_CSR - 1) begin
					ras_n_q <= 1'b0; // [RL17]
					cnt_q   <= 24'h000000;
					state_q <= S_CBR;
				end
			end
			S_CBR: begin
				if (sleep_req) begin
					// sleep only counts once the row strobe has been low long enough
					if (cnt_q >= SLEEP_CYC - 1) begin
						sleeping_q <= 1'b1; // [RL20]
						state_q    <= S_SLEEP;
					end
				end else if (cnt_q >= `C_CHR - 1 && ras_cnt_q >= `C_RAS - 1) begin
					cas_n_q <= 1'b1; // [RL17]
					cnt_q   <= 24'h000000;
					state_q <= S_CHR;
				end
			end
			S_CHR: begin
				if (cnt_q == `C_RP - 1) begin
					ras_n_q <= 1'b1; // [RL17]
					cnt_q   <= 24'h000000;
					state_q <= S_PRE;
				end
			end
			S_SLEEP: begin
				if (!sleep_req) begin
					ras_n_q    <= 1'b1; // [RL22]
					cas_n_q    <= 1'b1; // [RL22]
					sleeping_q <= 1'b0;
					cnt_q      <= 24'h000000;
					state_q    <= S_PRE;
				end
			end
			S_PRE: begin
				if (cnt_q == `C_RP - 1) begin
					state_q <= S_IDLE; // [RL10]
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule // dram_ctl

// ---- hw/dram_ctl_defines.vh ----
`ifndef DRAM_CTL_DEFINES_VH
`define DRAM_CTL_DEFINES_VH

// widths
`define ADDR_W        10
`define DATA_W        8
`define ROW_COUNT     11'h400

// request opcodes
`define OP_READ       2'h0
`define OP_WRITE      2'h1
`define OP_ROW_REF    2'h2

// timing figures in ns except T_SLEEP_US in us, clock period 4 ns
`define CLK_NS        4
`define T_ASR_NS      8
`define T_RAH_NS      12
`define T_RCD_NS      24
`define T_CAS_NS      24
`define T_RAS_NS      60
`define T_RP_NS       40
`define T_CSR_NS      12
`define T_CHR_NS      20
`define T_ACC_NS      60
`define T_REFI_NS     15600
`define T_SLEEP_US    100

// cycle counts, least times rounded up
`define CYC(ns)       (((ns) + `CLK_NS - 1) / `CLK_NS)
`define C_ASR         `CYC(`T_ASR_NS)
`define C_RAH         `CYC(`T_RAH_NS)
`define C_RCD         `CYC(`T_RCD_NS)
`define C_CAS         `CYC(`T_CAS_NS)
`define C_RAS         `CYC(`T_RAS_NS)
`define C_RP          `CYC(`T_RP_NS)
`define C_CSR         `CYC(`T_CSR_NS)
`define C_CHR         `CYC(`T_CHR_NS)
`define C_ACC         `CYC(`T_ACC_NS)
// longest interval rounds down, sleep minimum rounds up
`define C_REFI        ((`T_REFI_NS) / `CLK_NS)
`define C_SLEEP       ((`T_SLEEP_US * 1000 + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- hw/refresh_timer.v ----
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"

// raises due_q every period cycles until acknowledged
module refresh_timer #(
	parameter PERIOD = `C_REFI
) (
	// clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// request
	input  wire       ack,
	output reg        due_q
);
	reg  [15:0] cnt_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 16'h0000;
			due_q <= 1'b0;
		end else begin
			if (cnt_q == PERIOD[15:0] - 16'h0001) begin
				cnt_q <= 16'h0000;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
			// a new tick wins over a same-cycle acknowledge
			if (cnt_q == PERIOD[15:0] - 16'h0001) begin
				due_q <= 1'b1;
			end else if (ack) begin
				due_q <= 1'b0;
			end
		end
	end
endmodule // refresh_timer
